/* File: sirq_defines.vh */
// Constants for the system, interrupt and converter configuration bank.
// Assumes inclusion by sirq_regs.v only; definitions only, no logic.
`ifndef SIRQ_DEFINES_VH
`define SIRQ_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SIRQ_OFF_ID_HI      8'h00
`define SIRQ_OFF_ID_LO      8'h01
`define SIRQ_OFF_REV        8'h02
`define SIRQ_OFF_RSTCTL     8'h03
`define SIRQ_OFF_CLKGATE    8'h04
`define SIRQ_OFF_SERCFG     8'h08
`define SIRQ_OFF_IRQCTL     8'h09
`define SIRQ_OFF_IRQEN      8'h0A
`define SIRQ_OFF_IRQFLAG    8'h0B
`define SIRQ_OFF_PINMASK    8'h0C
`define SIRQ_OFF_PINFLAG    8'h0D
`define SIRQ_OFF_CONV1      8'h20
`define SIRQ_OFF_CONV2      8'h21
`define SIRQ_OFF_CAPT       8'h22
`define SIRQ_OFF_CH0        8'h30
`define SIRQ_OFF_CH1        8'h32
`define SIRQ_OFF_CH4        8'h38
`define SIRQ_OFF_CH5        8'h3A
`define SIRQ_OFF_CH6        8'h3C
`define SIRQ_OFF_CH7        8'h3E

// ----------------------------------------------------------------------
// Identity values (arbitrary, neutral)
// ----------------------------------------------------------------------
`define SIRQ_ID_VALUE       16'h5A3C
`define SIRQ_REV_VALUE      8'h07

// ----------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------
`define SIRQ_RST_RSTCTL     8'h00
`define SIRQ_RST_CLKGATE    8'h0F
`define SIRQ_RST_SERCFG     8'h01
`define SIRQ_RST_IRQCTL     8'h00
`define SIRQ_RST_IRQEN      8'h00
`define SIRQ_RST_IRQFLAG    8'h10
`define SIRQ_RST_PINMASK    8'h10
`define SIRQ_RST_PINFLAG    8'h00
`define SIRQ_RST_CONV1      8'h9C
`define SIRQ_RST_CONV2      8'h01
`define SIRQ_MSK_RSTCTL     8'h01
`define SIRQ_MSK_CLKGATE    8'h07
`define SIRQ_MSK_SERCFG     8'h07
`define SIRQ_MSK_IRQCTL     8'h07
`define SIRQ_MSK_IRQ        8'hDF
`define SIRQ_MSK_CONV1      8'h7A
`define SIRQ_MSK_CONV2      8'h03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SIRQ_RST_SOFT_BIT   1
`define SIRQ_RST_SLEEP_BIT  0
`define SIRQ_SER_STEP_BIT   2
`define SIRQ_CTL_POL_BIT    2
`define SIRQ_CTL_EDGE_BIT   1
`define SIRQ_CTL_GLOB_BIT   0
`define SIRQ_IRQ_PIN_BIT    7
`define SIRQ_IRQ_CONV_BIT   6
`define SIRQ_IRQ_EMPTY_BIT  4
`define SIRQ_IRQ_FULL_BIT   3
`define SIRQ_IRQ_OFLOW_BIT  2
`define SIRQ_IRQ_LEVEL_BIT  1
`define SIRQ_IRQ_TOUCH_BIT  0
`define SIRQ_CV_RES_BIT     3
`define SIRQ_CV_REF_BIT     1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SIRQ_STRAP_WAIT     2'h3

`endif

/* File: sirq_regs.v */
// Register bank: identity, reset and sleep, clock gating, serial config,
// two-tier interrupt tree and converter configuration.
// Assumes the serial engine and the event sources run on clk_sys.
`timescale 1ns/1ps
`include "sirq_defines.vh"

module sirq_regs (
  input  wire        clk_sys,            // System clock, 100 MHz.
  input  wire        rst_n,              // Power-up reset, async, low.
  input  wire [7:0]  regAddr,            // Register address from serial.
  input  wire [7:0]  regWrData,          // Write data.
  input  wire        regWrEn,            // Write strobe, one cycle.
  input  wire        regRdEn,            // Read strobe, one cycle.
  output reg  [7:0]  regRdData,          // Read data, valid after strobe.
  input  wire        addressStrapPin,    // Strap pin, asynchronous.
  input  wire [7:0]  pinEvent,           // Per-pin event pulses.
  input  wire        converterEvent,     // Any converter event pulse.
  input  wire        contactEvent,       // Touch detected pulse.
  input  wire        queueOverflowEvent, // Queue overflow pulse.
  input  wire        queueFullEvent,     // Queue full pulse.
  input  wire        queueEmptyEvent,    // Queue empty pulse.
  input  wire [7:0]  queueFill,          // Current queue fill level.
  input  wire [7:0]  queueThreshold,     // Queue threshold setting.
  input  wire [7:0]  captureBusy,        // Channels still converting.
  input  wire [11:0] resultCh0,          // Result, analog input b.
  input  wire [11:0] resultCh1,          // Result, analog input a.
  input  wire [11:0] resultCh4,          // Result, touch channel 4.
  input  wire [11:0] resultCh5,          // Result, touch channel 5.
  input  wire [11:0] resultCh6,          // Result, touch channel 6.
  input  wire [11:0] resultCh7,          // Result, touch channel 7.
  output reg         softResetPulse,     // Whole-device reset request.
  output reg         forcedSleep,        // Force hibernation.
  output reg         hotKeyWakeEnable,   // Hot-key wake allowed.
  output reg         pinUnitClockGate,   // Stop pin unit clock.
  output reg         touchUnitClockGate, // Stop touch unit clock.
  output reg         convUnitClockGate,  // Stop converter clock.
  output reg         addressStepEnable,  // Auto-stepped addressing.
  output reg  [1:0]  serialClockStyle,   // Serial clock mode bits.
  output reg  [6:0]  conversionCycles,   // Conversion time, 0 = invalid.
  output reg         resolutionSelect,   // 1 = 12-bit results.
  output reg         externalRefSelect,  // 1 = external reference.
  output reg  [1:0]  converterFreqSel,   // Converter clock field.
  output reg  [7:0]  captureStrobe,      // Start-capture pulses.
  output reg         irqPin              // Interrupt output pin level.
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function [6:0] convTime;
    input [2:0] code;
    begin
      case (code)
        3'h0:    convTime = 7'h24;
        3'h1:    convTime = 7'h2C;
        3'h2:    convTime = 7'h38;
        3'h3:    convTime = 7'h40;
        3'h4:    convTime = 7'h50;
        3'h5:    convTime = 7'h60;
        3'h6:    convTime = 7'h7C;
        default: convTime = 7'h00;
      endcase
    end
  endfunction

  function hit;
    input [7:0] off;
    begin
      hit = (regAddr == off);
    end
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  [7:0] rstCtl;
  reg  [7:0] clkGate;
  reg  [7:0] serCfg;
  reg  [7:0] irqCtl;
  reg  [7:0] irqEn;
  reg  [7:0] irqFlag;
  reg  [7:0] pinMask;
  reg  [7:0] pinFlag;
  reg  [7:0] conv1;
  reg  [7:0] conv2;
  reg        softPending;
  reg        levelArmed;
  reg        irqPendingQ;
  reg        strapSync1;
  reg        strapSync2;
  reg  [1:0] strapCnt;
  reg        strapDone;
  reg  [7:0] readValue;
  wire       wr;
  wire       levelReached;
  wire [7:0] irqSet;
  wire       irqPending;
  wire       irqActive;
  wire       pinRead;
  wire [15:0] idWord;

  assign idWord       = `SIRQ_ID_VALUE;
  assign wr           = regWrEn;
  assign pinRead      = regRdEn & hit(`SIRQ_OFF_PINFLAG);
  assign levelReached = (queueFill >= queueThreshold);

  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  // The strap is synchronised, then taken once a few cycles after release.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strapSync1 <= 1'b0;
      strapSync2 <= 1'b0;
      strapCnt   <= 2'h0;
      strapDone  <= 1'b0;
    end else begin
      strapSync1 <= addressStrapPin;
      strapSync2 <= strapSync1;
      if (strapCnt != `SIRQ_STRAP_WAIT) begin
        strapCnt <= strapCnt + 2'h1;
      end
      if (strapCnt == `SIRQ_STRAP_WAIT) begin
        strapDone <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Event sets
  // --------------------------------------------------------------------
  assign irqSet[`SIRQ_IRQ_PIN_BIT]   = |(pinEvent & pinMask);
  assign irqSet[`SIRQ_IRQ_CONV_BIT]  = converterEvent;
  assign irqSet[5]                   = 1'b0;
  assign irqSet[`SIRQ_IRQ_EMPTY_BIT] = queueEmptyEvent;
  assign irqSet[`SIRQ_IRQ_FULL_BIT]  = queueFullEvent;
  assign irqSet[`SIRQ_IRQ_OFLOW_BIT] = queueOverflowEvent;
  assign irqSet[`SIRQ_IRQ_LEVEL_BIT] = levelReached & levelArmed;
  assign irqSet[`SIRQ_IRQ_TOUCH_BIT] = contactEvent;

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // A soft reset returns every register to its power-up value one cycle
  // after the request, except serCfg[1:0], which keeps its current value, and the strap capture, which is power-up only.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstCtl      <= `SIRQ_RST_RSTCTL;
      clkGate     <= `SIRQ_RST_CLKGATE & `SIRQ_MSK_CLKGATE;
      serCfg      <= `SIRQ_RST_SERCFG;
      irqCtl      <= `SIRQ_RST_IRQCTL;
      irqEn       <= `SIRQ_RST_IRQEN;
      irqFlag     <= `SIRQ_RST_IRQFLAG;
      pinMask     <= `SIRQ_RST_PINMASK;
      pinFlag     <= `SIRQ_RST_PINFLAG;
      conv1       <= `SIRQ_RST_CONV1 & `SIRQ_MSK_CONV1;
      conv2       <= `SIRQ_RST_CONV2;
      softPending <= 1'b0;
      levelArmed  <= 1'b1;
    end else if (softPending) begin
      rstCtl      <= `SIRQ_RST_RSTCTL;
      clkGate     <= `SIRQ_RST_CLKGATE & `SIRQ_MSK_CLKGATE;
      serCfg      <= {5'h00, 1'b0, serCfg[1:0]};
      irqCtl      <= `SIRQ_RST_IRQCTL;
      irqEn       <= `SIRQ_RST_IRQEN;
      irqFlag     <= `SIRQ_RST_IRQFLAG;
      pinMask     <= `SIRQ_RST_PINMASK;
      pinFlag     <= `SIRQ_RST_PINFLAG;
      conv1       <= `SIRQ_RST_CONV1 & `SIRQ_MSK_CONV1;
      conv2       <= `SIRQ_RST_CONV2;
      softPending <= 1'b0;
      levelArmed  <= 1'b1;
    end else begin
      softPending <= wr & hit(`SIRQ_OFF_RSTCTL) &
                     regWrData[`SIRQ_RST_SOFT_BIT];
      if (wr && hit(`SIRQ_OFF_RSTCTL)) begin
        rstCtl <= regWrData & `SIRQ_MSK_RSTCTL;
      end
      if (wr && hit(`SIRQ_OFF_CLKGATE)) begin
        clkGate <= regWrData & `SIRQ_MSK_CLKGATE;
      end
      if (!strapDone && strapCnt == `SIRQ_STRAP_WAIT) begin
        serCfg[1:0] <= {strapSync2, strapSync2};
      end else if (wr && hit(`SIRQ_OFF_SERCFG)) begin
        serCfg <= regWrData & `SIRQ_MSK_SERCFG;
      end
      if (wr && hit(`SIRQ_OFF_IRQCTL)) begin
        irqCtl <= regWrData & `SIRQ_MSK_IRQCTL;
      end
      if (wr && hit(`SIRQ_OFF_IRQEN)) begin
        irqEn <= regWrData & `SIRQ_MSK_IRQ;
      end
      if (wr && hit(`SIRQ_OFF_IRQFLAG)) begin
        irqFlag <= (irqFlag & ~regWrData) | irqSet;
      end else begin
        irqFlag <= irqFlag | irqSet;
      end
      if (wr && hit(`SIRQ_OFF_PINMASK)) begin
        pinMask <= regWrData;
      end
      // Set wins over the clear-on-read in the same cycle.
      if (pinRead) begin
        pinFlag <= pinEvent;
      end else begin
        pinFlag <= pinFlag | pinEvent;
      end
      if (wr && hit(`SIRQ_OFF_CONV1)) begin
        conv1 <= regWrData & `SIRQ_MSK_CONV1;
      end
      if (wr && hit(`SIRQ_OFF_CONV2)) begin
        conv2 <= regWrData & `SIRQ_MSK_CONV2;
      end
      if (!levelReached) begin
        levelArmed <= 1'b1;
      end else if (levelArmed) begin
        levelArmed <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always @* begin
    readValue = 8'h00;
    case (regAddr)
      `SIRQ_OFF_ID_HI:   readValue = idWord[15:8];
      `SIRQ_OFF_ID_LO:   readValue = idWord[7:0];
      `SIRQ_OFF_REV:     readValue = `SIRQ_REV_VALUE;
      `SIRQ_OFF_RSTCTL:  readValue = rstCtl;
      `SIRQ_OFF_CLKGATE: readValue = clkGate;
      `SIRQ_OFF_SERCFG:  readValue = serCfg;
      `SIRQ_OFF_IRQCTL:  readValue = irqCtl;
      `SIRQ_OFF_IRQEN:   readValue = irqEn;
      `SIRQ_OFF_IRQFLAG: readValue = irqFlag;
      `SIRQ_OFF_PINMASK: readValue = pinMask;
      `SIRQ_OFF_PINFLAG: readValue = pinFlag;
      `SIRQ_OFF_CONV1:   readValue = conv1;
      `SIRQ_OFF_CONV2:   readValue = conv2;
      `SIRQ_OFF_CAPT:    readValue = captureBusy;
      // Results are 12 bits, high nibble at the even offset.
      `SIRQ_OFF_CH0:        readValue = {4'h0, resultCh0[11:8]};
      `SIRQ_OFF_CH0 + 8'h1: readValue = resultCh0[7:0];
      `SIRQ_OFF_CH1:        readValue = {4'h0, resultCh1[11:8]};
      `SIRQ_OFF_CH1 + 8'h1: readValue = resultCh1[7:0];
      `SIRQ_OFF_CH4:        readValue = {4'h0, resultCh4[11:8]};
      `SIRQ_OFF_CH4 + 8'h1: readValue = resultCh4[7:0];
      `SIRQ_OFF_CH5:        readValue = {4'h0, resultCh5[11:8]};
      `SIRQ_OFF_CH5 + 8'h1: readValue = resultCh5[7:0];
      `SIRQ_OFF_CH6:        readValue = {4'h0, resultCh6[11:8]};
      `SIRQ_OFF_CH6 + 8'h1: readValue = resultCh6[7:0];
      `SIRQ_OFF_CH7:        readValue = {4'h0, resultCh7[11:8]};
      `SIRQ_OFF_CH7 + 8'h1: readValue = resultCh7[7:0];
      default:           readValue = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Interrupt pin
  // --------------------------------------------------------------------
  assign irqPending = irqCtl[`SIRQ_CTL_GLOB_BIT] &
                      (|(irqFlag & irqEn));
  // Edge style gives a one-cycle pulse each time irqPending rises, none for further conditions while it stays set.
  assign irqActive  = irqCtl[`SIRQ_CTL_EDGE_BIT] ?
                      (irqPending & ~irqPendingQ) : irqPending;

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData          <= 8'h00;
      softResetPulse     <= 1'b0;
      forcedSleep        <= 1'b0;
      hotKeyWakeEnable   <= 1'b1;
      pinUnitClockGate   <= 1'b0;
      touchUnitClockGate <= 1'b0;
      convUnitClockGate  <= 1'b0;
      addressStepEnable  <= 1'b0;
      serialClockStyle   <= 2'h0;
      conversionCycles   <= 7'h00;
      resolutionSelect   <= 1'b0;
      externalRefSelect  <= 1'b0;
      converterFreqSel   <= 2'h0;
      captureStrobe      <= 8'h00;
      irqPendingQ        <= 1'b0;
      irqPin             <= 1'b1;
    end else begin
      if (regRdEn) begin
        regRdData <= readValue;
      end
      softResetPulse     <= softPending;
      forcedSleep        <= rstCtl[`SIRQ_RST_SLEEP_BIT];
      hotKeyWakeEnable   <= ~rstCtl[`SIRQ_RST_SLEEP_BIT];
      pinUnitClockGate   <= clkGate[2];
      touchUnitClockGate <= clkGate[1];
      convUnitClockGate  <= clkGate[0];
      addressStepEnable  <= serCfg[`SIRQ_SER_STEP_BIT];
      serialClockStyle   <= serCfg[1:0];
      conversionCycles   <= convTime(conv1[6:4]);
      resolutionSelect   <= conv1[`SIRQ_CV_RES_BIT];
      externalRefSelect  <= conv1[`SIRQ_CV_REF_BIT];
      converterFreqSel   <= conv2[1:0];
      captureStrobe      <= (wr && hit(`SIRQ_OFF_CAPT) && !softPending) ?
                            regWrData : 8'h00;
      irqPendingQ        <= irqPending;
      irqPin             <= irqActive ~^ irqCtl[`SIRQ_CTL_POL_BIT];
    end
  end

endmodule // sirq_regs

/* File: sirq_host_model.sv */
// Host processor model driving the register port of the bank.
// Assumes one clk_sys; requests change at the falling edge only.
`timescale 1ns/1ps

module sirq_host_model (
  input  wire        clk_sys,   // System clock.
  output logic [7:0] regAddr,   // Register address.
  output logic [7:0] regWrData, // Write data.
  output logic       regWrEn,   // Write strobe.
  output logic       regRdEn,   // Read strobe.
  input  wire  [7:0] regRdData  // Read data.
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle lines carry the inverse of the last value so that nothing
  // can pass for a held request.
  initial begin
    regAddr = 8'hFF;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule // sirq_host_model

/* File: sirq_regs_props.sv */
// Checker for the register bank, bound to its ports.
// Assumes the strap pin is held steady across each reset release.
`timescale 1ns/1ps

module sirq_regs_props (
  input wire        clk_sys,            // System clock.
  input wire        rst_n,              // Reset, active low.
  input wire [7:0]  regAddr,            // Register address.
  input wire [7:0]  regWrData,          // Write data.
  input wire        regWrEn,            // Write strobe.
  input wire        regRdEn,            // Read strobe.
  input wire [7:0]  regRdData,          // Read data.
  input wire        addressStrapPin,    // Strap pin.
  input wire [7:0]  pinEvent,           // Pin events.
  input wire        softResetPulse,     // Soft reset pulse.
  input wire        forcedSleep,        // Forced sleep.
  input wire        hotKeyWakeEnable,   // Hot-key wake.
  input wire        pinUnitClockGate,   // Pin clock gate.
  input wire        touchUnitClockGate, // Touch clock gate.
  input wire        convUnitClockGate,  // Converter clock gate.
  input wire [1:0]  serialClockStyle,   // Serial clock mode.
  input wire [6:0]  conversionCycles,   // Conversion time.
  input wire        irqPin              // Interrupt pin.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  function automatic logic [6:0] cyc(input logic [2:0] c);
    case (c)
      3'h0: cyc = 7'h24;
      3'h1: cyc = 7'h2C;
      3'h2: cyc = 7'h38;
      3'h3: cyc = 7'h40;
      3'h4: cyc = 7'h50;
      3'h5: cyc = 7'h60;
      3'h6: cyc = 7'h7C;
      default: cyc = 7'h00;
    endcase
  endfunction

  chk_soft_reset_pulse: assert property (
    regWrEn && regAddr == 8'h03 && regWrData[1] |->
      ##2 softResetPulse ##1 !softResetPulse) else $error("soft pulse");
  chk_sleep_wake_pair: assert property (
    forcedSleep != hotKeyWakeEnable) else $error("sleep pair");
  chk_gate_follow: assert property (
    regWrEn && regAddr == 8'h04 |-> ##2 {pinUnitClockGate,
      touchUnitClockGate, convUnitClockGate} == $past(regWrData[2:0], 2))
    else $error("clock gates");
  chk_strap_capture: assert property (
    $rose(rst_n) |-> ##[5:8] serialClockStyle == {2{addressStrapPin}})
    else $error("strap capture");
  chk_irq_global_off: assert property (
    regWrEn && regAddr == 8'h09 && !regWrData[0] |->
      ##2 irqPin == !$past(regWrData[2], 2)) else $error("global off");
  chk_pin_flag_clear: assert property (
    regRdEn && regAddr == 8'h0D && pinEvent == 8'h00 ##1
      pinEvent == 8'h00 ##1 regRdEn && regAddr == 8'h0D |=>
      regRdData == 8'h00) else $error("pin flag clear");
  chk_conv_time: assert property (
    regWrEn && regAddr == 8'h20 |->
      ##2 conversionCycles == cyc($past(regWrData[6:4], 2)))
    else $error("conversion time");
  chk_identity_high: assert property (
    regRdEn && regAddr == 8'h00 |=> regRdData == 8'h5A)
    else $error("identity");
  chk_unmapped_zero: assert property (
    regRdEn && (regAddr == 8'h05 || regAddr == 8'h40) |=>
      regRdData == 8'h00) else $error("unmapped read");

  cover property (softResetPulse);
  cover property ($fell(irqPin));
  cover property (regRdEn && regAddr == 8'h0D ##2 regRdEn);
endmodule // sirq_regs_props

bind sirq_regs sirq_regs_props chk (.clk_sys, .rst_n, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .addressStrapPin,
  .pinEvent, .softResetPulse, .forcedSleep, .hotKeyWakeEnable,
  .pinUnitClockGate, .touchUnitClockGate, .convUnitClockGate,
  .serialClockStyle, .conversionCycles, .irqPin);

/* File: sys_irq_adc_config_regs_bench.sv */
// Self-checking bench for the register bank.
// Assumes sirq_regs, the host model and the bound checker.
`timescale 1ns/1ps

module sys_irq_adc_config_regs_bench;
  logic clk_sys, rst_n, addressStrapPin, converterEvent, contactEvent;
  logic queueOverflowEvent, queueFullEvent, queueEmptyEvent;
  logic [7:0]  pinEvent, queueFill, queueThreshold, captureBusy, v;
  logic [11:0] resultCh0, resultCh1, resultCh4, resultCh5;
  logic [11:0] resultCh6, resultCh7;
  wire  [7:0]  regAddr, regWrData, regRdData, captureStrobe;
  wire  [6:0]  conversionCycles;
  wire  [1:0]  serialClockStyle, converterFreqSel;
  wire regWrEn, regRdEn, softResetPulse, forcedSleep, hotKeyWakeEnable;
  wire pinUnitClockGate, touchUnitClockGate, convUnitClockGate;
  wire addressStepEnable, resolutionSelect, externalRefSelect, irqPin;
  int mismatches = 0, nCompared = 0, i, n;
  logic [7:0] ra [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h20, 8'h21, 8'h22, 8'h05, 8'h30};
  logic [7:0] re [16] = '{8'h5A, 8'h3C, 8'h07, 8'h00, 8'h07, 8'h03,
    8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h18, 8'h01, 8'hA5, 8'h00, 8'h0A};
  logic [7:0] wa [8] = '{8'h00, 8'h04, 8'h08, 8'h0A, 8'h0C, 8'h20,
    8'h21, 8'h0D};
  logic [7:0] we [8] = '{8'h5A, 8'h07, 8'h07, 8'hDF, 8'hFF, 8'h7A,
    8'h03, 8'h00};
  logic [6:0] ct [8] = '{7'h24, 7'h2C, 7'h38, 7'h40, 7'h50, 7'h60,
    7'h7C, 7'h00};
  logic [2:0] fb [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};

  sirq_regs DUT (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .addressStrapPin, .pinEvent, .converterEvent,
    .contactEvent, .queueOverflowEvent, .queueFullEvent, .queueEmptyEvent,
    .queueFill, .queueThreshold, .captureBusy, .resultCh0, .resultCh1,
    .resultCh4, .resultCh5, .resultCh6, .resultCh7, .softResetPulse,
    .forcedSleep, .hotKeyWakeEnable, .pinUnitClockGate,
    .touchUnitClockGate, .convUnitClockGate, .addressStepEnable,
    .serialClockStyle, .conversionCycles, .resolutionSelect,
    .externalRefSelect, .converterFreqSel, .captureStrobe, .irqPin);
  sirq_host_model host (.clk_sys, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    nCompared++;
    if (seen !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    check($sformatf("reg %h", a), v, e);
  endtask
  task tick;
    @(negedge clk_sys);
  endtask
  // Event pulses last exactly one cycle so each sets its flag once.
  task ev(input logic [7:0] m, input logic [7:0] p);
    @(negedge clk_sys);
    {converterEvent, queueEmptyEvent, queueFullEvent} = {m[6], m[4], m[3]};
    {queueOverflowEvent, contactEvent, pinEvent} = {m[2], m[0], p};
    @(negedge clk_sys);
    {converterEvent, queueEmptyEvent, queueFullEvent} = 3'h0;
    {queueOverflowEvent, contactEvent, pinEvent} = 10'h000;
  endtask
  task finish_test;
    if (mismatches == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, addressStrapPin, converterEvent, contactEvent} = 4'h4;
    {queueOverflowEvent, queueFullEvent, queueEmptyEvent} = 3'h0;
    {pinEvent, queueFill, queueThreshold, captureBusy} = 32'h000005A5;
    {resultCh0, resultCh1, resultCh4} = 36'hABC456789;
    {resultCh5, resultCh6, resultCh7} = 36'h321654FED;
    repeat (5) tick;
    rst_n = 1'b1;
    repeat (8) tick;
    for (i = 0; i < 16; i++) rdc(ra[i], re[i]);
    rdc(8'h3F, 8'hED);
    check("style", 8'(serialClockStyle), 8'h03);
    for (i = 0; i < 8; i++) begin
      host.wr(wa[i], 8'hFF);
      rdc(wa[i], we[i]);
    end
    check("freq", 8'(converterFreqSel), 8'h03);
    check("step", 8'(addressStepEnable), 8'h01);
    host.wr(8'h04, 8'h05);
    tick;
    check("gates", {5'h00, pinUnitClockGate, touchUnitClockGate,
      convUnitClockGate}, 8'h05);
    for (i = 0; i < 8; i++) begin
      host.wr(8'h20, {1'b0, 3'(i), 4'h2});
      tick;
      check("cycles", 8'(conversionCycles), 8'(ct[i]));
      check("resolution", 8'(resolutionSelect), 8'h00);
      check("reference", 8'(externalRefSelect), 8'h01);
    end
    host.wr(8'h20, 8'h08);
    tick;
    check("resolution", 8'(resolutionSelect), 8'h01);
    host.wr(8'h22, 8'h3C);
    check("strobe", captureStrobe, 8'h3C);
    host.wr(8'h03, 8'h01);
    tick;
    check("wake", 8'(hotKeyWakeEnable), 8'h00);
    check("sleep", 8'(forcedSleep), 8'h01);
    host.wr(8'h03, 8'h00);
    // Pending flags with all enables off must keep the pin quiet.
    host.wr(8'h0A, 8'h00);
    host.wr(8'h09, 8'h01);
    host.wr(8'h0B, 8'hFF);
    rdc(8'h0B, 8'h00);
    for (i = 0; i < 5; i++) begin
      ev(8'h01 << fb[i], 8'h00);
      host.wr(8'h0B, 8'h00);
      rdc(8'h0B, 8'h01 << fb[i]);
      check("pin", 8'(irqPin), 8'h01);
      host.wr(8'h0B, 8'h01 << fb[i]);
    end
    host.wr(8'h0C, 8'h01);
    ev(8'h00, 8'h82);
    rdc(8'h0B, 8'h00);
    ev(8'h00, 8'h01);
    rdc(8'h0B, 8'h80);
    rdc(8'h0D, 8'h83);
    rdc(8'h0D, 8'h00);
    host.wr(8'h0B, 8'h80);
    host.wr(8'h0A, 8'h01);
    ev(8'h01, 8'h00);
    repeat (3) tick;
    check("pin low", 8'(irqPin), 8'h00);
    host.wr(8'h09, 8'h00);
    tick;
    check("pin off", 8'(irqPin), 8'h01);
    host.wr(8'h09, 8'h05);
    tick;
    check("pin high", 8'(irqPin), 8'h01);
    host.wr(8'h0B, 8'h01);
    tick;
    check("pin idle", 8'(irqPin), 8'h00);
    host.wr(8'h09, 8'h07);
    ev(8'h01, 8'h00);
    n = 0;
    for (i = 0; i < 6; i++) begin
      tick;
      n += int'(irqPin === 1'b1);
    end
    check("edge count", 8'(n), 8'h01);
    host.wr(8'h0B, 8'hFF);
    tick;
    {queueThreshold, queueFill} = 16'h0303;
    rdc(8'h0B, 8'h02);
    host.wr(8'h0B, 8'h02);
    rdc(8'h0B, 8'h00);
    tick;
    queueFill = 8'h02;
    tick;
    queueFill = 8'h03;
    rdc(8'h0B, 8'h02);
    host.wr(8'h03, 8'h02);
    for (i = 0; i < 10 && softResetPulse !== 1'b1; i++) tick;
    if (softResetPulse !== 1'b1) begin
      mismatches++;
    end else begin
      rdc(8'h0A, 8'h00);
      rdc(8'h03, 8'h00);
      rdc(8'h08, 8'h03);
    end
    finish_test;
  end
endmodule // sys_irq_adc_config_regs_bench
